/* cals_pkg.sv */
// Purpose: Shared constants and types for the addressing and load/store core
// Assumes: 8-bit data space, 12-bit program space, one 10 MHz clock
// Notes:   Opcode patterns use casez wildcards; phase counts are cycles
package cals_pkg;

  // ==========================================================================
  // Widths and spaces
  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 6;
  localparam logic [7:0] SCR_BASE = 8'h80;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [7:0] ACC_RST = 8'h00;

  // ==========================================================================
  // Cycle counts and instruction lengths
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_MEM = 3'h4;
  localparam logic [2:0] CYC_BTEST = 3'h5;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // ==========================================================================
  // Opcode patterns
  localparam logic [7:0] OPC_SHORT = 8'b0000_?0??;
  localparam logic [7:0] OPC_BTEST = 8'b0001_????;
  localparam logic [7:0] OPC_INDIR = 8'b001?_000?;
  localparam logic [7:0] OPC_LD_DIR = 8'h40;
  localparam logic [7:0] OPC_ST_DIR = 8'h41;
  localparam logic [7:0] OPC_LDI_A = 8'h42;
  localparam logic [7:0] OPC_LDI_M = 8'h43;
  localparam logic [7:0] OPC_RET = 8'h44;
  localparam logic [7:0] OPC_NOP = 8'h45;
  localparam logic [7:0] OPC_CALL = 8'b0101_????;
  localparam logic [7:0] OPC_JUMP = 8'b0110_????;
  localparam logic [7:0] OPC_BIT = 8'b0111_????;
  localparam logic [7:0] OPC_REL = 8'b1???_????;
  // Field positions
  localparam int PTR_BIT = 4;
  localparam int DIR_BIT = 4;
  localparam int SENSE_BIT = 3;

  // ==========================================================================
  // Addressing modes and operations
  typedef enum logic [3:0] {
    MODE_SHORT, MODE_INDIRECT, MODE_DIRECT, MODE_IMM, MODE_IMM_MEM,
    MODE_EXT, MODE_REL, MODE_BIT, MODE_BITTEST, MODE_INH
  } cals_mode_t;

  typedef enum logic [3:0] {
    OP_LOAD, OP_STORE, OP_LOADI_A, OP_LOADI_M, OP_JUMP, OP_CALL,
    OP_RET, OP_NOP, OP_BSET, OP_BCLR, OP_BTEST, OP_BRANCH
  } cals_op_t;

  // Scratch cells sit at 80h..83h and live inside the core
  function automatic logic is_scratch(input logic [7:0] addr);
    return addr[7:2] == SCR_BASE[7:2];
  endfunction

endpackage

/* cals_dec_if.sv */
// Purpose: Carries an opcode to the decoder and its decoded fields back
// Assumes: Purely combinational path within one cycle
// Notes:   Modport dec for the decoder, core for the sequencer
`timescale 1ns/10ps
`default_nettype none
interface cals_dec_if;
  import cals_pkg::*;
  logic [7:0] opcode;
  cals_mode_t mode;
  cals_op_t op;
  logic [1:0] len;
  logic [2:0] ncyc;
  logic [2:0] bitn;
  logic sense;
  logic ptr_sel;
  logic [1:0] reg_sel;
  logic legal;
  modport dec(input opcode, output mode, op, len, ncyc, bitn, sense,
              ptr_sel, reg_sel, legal);
  modport core(output opcode, input mode, op, len, ncyc, bitn, sense,
               ptr_sel, reg_sel, legal);
endinterface
`default_nettype wire

/* cals_decode.sv */
// Purpose: Opcode decoder: addressing mode, operation, length and cycles
// Assumes: Opcode is stable for the whole cycle
// Notes:   Unknown opcodes decode as a one-byte, two-cycle no-op
`timescale 1ns/10ps
`default_nettype none
module cals_decode (
  cals_dec_if.dec dif
);
  import cals_pkg::*;

  // ==========================================================================
  // Field extraction, shared by every group
  assign dif.bitn = dif.opcode[2:0];
  assign dif.sense = dif.opcode[SENSE_BIT];
  // RULE12: pointer chosen by bit 4
  assign dif.ptr_sel = dif.opcode[PTR_BIT];
  assign dif.reg_sel = dif.opcode[1:0];

  // ==========================================================================
  // Group decode
  // RULE14: subset of the opcode map
  always_comb begin
    dif.mode = MODE_INH;
    dif.op = OP_NOP;
    dif.len = LEN_1;
    dif.ncyc = CYC_SHORT;
    dif.legal = 1'b1;
    casez (dif.opcode)
      // RULE5: register picked by opcode, no address byte
      OPC_SHORT: begin
        dif.mode = MODE_SHORT;
        dif.op = dif.opcode[3] ? OP_STORE : OP_LOAD;
        dif.ncyc = CYC_MEM;
      end
      // RULE10: three-byte bit test
      OPC_BTEST: begin
        dif.mode = MODE_BITTEST;
        dif.op = OP_BTEST;
        dif.len = LEN_3;
        dif.ncyc = CYC_BTEST;
      end
      OPC_INDIR: begin
        dif.mode = MODE_INDIRECT;
        dif.op = dif.opcode[0] ? OP_STORE : OP_LOAD;
        dif.ncyc = CYC_MEM;
      end
      // RULE17: two- and three-byte load forms
      OPC_LD_DIR, OPC_ST_DIR: begin
        dif.mode = MODE_DIRECT;
        dif.op = dif.opcode[0] ? OP_STORE : OP_LOAD;
        dif.len = LEN_2;
        dif.ncyc = CYC_MEM;
      end
      OPC_LDI_A: begin
        dif.mode = MODE_IMM;
        dif.op = OP_LOADI_A;
        dif.len = LEN_2;
        dif.ncyc = CYC_MEM;
      end
      OPC_LDI_M: begin
        dif.mode = MODE_IMM_MEM;
        dif.op = OP_LOADI_M;
        dif.len = LEN_3;
        dif.ncyc = CYC_MEM;
      end
      // RULE13: one byte, opcode alone
      OPC_RET: begin
        dif.op = OP_RET;
      end
      OPC_NOP: begin
        dif.op = OP_NOP;
      end
      OPC_CALL, OPC_JUMP: begin
        dif.mode = MODE_EXT;
        dif.op = dif.opcode[5] ? OP_JUMP : OP_CALL;
        dif.len = LEN_2;
        dif.ncyc = CYC_MEM;
      end
      OPC_BIT: begin
        dif.mode = MODE_BIT;
        dif.op = dif.opcode[3] ? OP_BCLR : OP_BSET;
        dif.len = LEN_2;
        dif.ncyc = CYC_MEM;
      end
      // RULE7: condition, direction and magnitude fields
      OPC_REL: begin
        dif.mode = MODE_REL;
        dif.op = OP_BRANCH;
      end
      default: begin
        dif.legal = 1'b0;
      end
    endcase
  end

endmodule // cals_decode
`default_nettype wire

/* cals_core.sv */
// Purpose: Fetch, operand addressing and load/store sequencing of the core
// Assumes: Program and data memories answer in the cycle the address stands
// Notes:   Scratch cells 80h..83h are held here and never reach the bus
//
// Summary of operation
// RULE1: Opcodes and immediate constants come from program space only.
// RULE2: Return addresses go to a six-cell 12-bit stack.
// RULE3: Immediate operand is the byte right after the opcode.
// RULE4: Direct mode uses the next byte as 8-bit data address.
// RULE5: Short-direct opcode selects one of the cells 80h..83h.
// RULE6: Jump and call target is opcode low nibble then next byte.
// RULE7: Relative opcode holds condition, direction bit and 4-bit magnitude.
// RULE8: Taken relative branch spans -15..+16; else next instruction follows.
// RULE9: Bit set or clear changes only the chosen bit.
// RULE10: Bit test branch is three bytes, displacement -127..+128.
// RULE11: Any data-space bit can steer a branch.
// RULE12: Indirect mode uses cell 80h or 81h, chosen by bit 4.
// RULE13: Inherent instructions are one byte, opcode alone.
// RULE14: Decoder covers the instruction groups; unknown opcodes are flagged.
// RULE15: Loads and stores move data between accumulator and memory.
// RULE16: Immediate-to-memory writes a program constant to any address.
// RULE17: Load forms take one to three bytes and four cycles.
// RULE18: Loads and stores update zero; immediate-to-memory keeps flags.
`timescale 1ns/10ps
`default_nettype none
module cals_core #(
  parameter int STACK_CELLS = cals_pkg::STACK_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic [cals_pkg::PC_W-1:0] prog_addr_out,
  input wire logic [cals_pkg::DATA_W-1:0] prog_data_in,
  output logic [cals_pkg::DATA_W-1:0] data_addr_out,
  input wire logic [cals_pkg::DATA_W-1:0] data_rdata_in,
  output logic [cals_pkg::DATA_W-1:0] data_wdata_out,
  output logic data_we_out,
  output logic [cals_pkg::DATA_W-1:0] acc_out,
  output logic zero_out,
  output logic carry_out,
  output logic [cals_pkg::PC_W-1:0] pc_out,
  output logic instr_done_out,
  output logic bad_opcode_out
);
  import cals_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [2:0] ph;
    logic [11:0] pc;
    logic [11:0] fa;
    logic [7:0] ir;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] acc;
    logic z;
    logic c;
    logic [3:0][7:0] scr;
    logic [STACK_CELLS-1:0][11:0] stk;
    logic [7:0] daddr;
    logic [7:0] dwd;
    logic dwe;
    logic bad;
  } cals_state_t;

  cals_state_t s;
  cals_state_t next_s;
  cals_dec_if dif();
  logic [2:0] last_ph;
  logic [7:0] operand;
  logic [7:0] mask;
  logic [7:0] wval;
  logic wr;
  logic taken;
  logic [11:0] next_pc;

  cals_decode u_dec (
    .dif(dif)
  );

  // RULE1: opcode straight from program space in phase 0
  assign dif.opcode = (s.ph == 3'h0) ? prog_data_in : s.ir;
  assign last_ph = dif.ncyc - 3'h1;
  // Scratch cells are internal so a short access needs no bus cycle
  assign operand = is_scratch(s.daddr) ? s.scr[s.daddr[1:0]] : data_rdata_in;
  assign mask = 8'h01 << dif.bitn;

  // ==========================================================================
  // Sequencer: phase 0 opcode, 1 and 2 operand bytes, last phase retires
  always_comb begin
    next_s = s;
    next_s.dwe = 1'b0;
    wr = 1'b0;
    wval = 8'h00;
    taken = 1'b0;
    next_pc = s.pc + {10'h000, dif.len};
    case (s.ph)
      3'h0: begin
        next_s.ir = prog_data_in;
        next_s.fa = s.pc + 12'h001;
        next_s.bad = !dif.legal;
        // RULE5: short cell address from opcode
        if (dif.mode == MODE_SHORT) begin
          next_s.daddr = SCR_BASE | {6'h00, dif.reg_sel};
        end
        // RULE12: pointer cell content is the address
        if (dif.mode == MODE_INDIRECT) begin
          next_s.daddr = s.scr[{1'b0, dif.ptr_sel}];
        end
      end
      3'h1: begin
        next_s.b1 = prog_data_in;
        next_s.fa = s.pc + 12'h002;
        // RULE4: second byte is the data address
        if (dif.mode inside {MODE_DIRECT, MODE_BIT, MODE_BITTEST,
                             MODE_IMM_MEM}) begin
          next_s.daddr = prog_data_in;
        end
      end
      3'h2: begin
        next_s.b2 = prog_data_in;
        case (dif.op)
          // RULE15: memory to accumulator
          OP_LOAD: begin
            next_s.acc = operand;
            // RULE18: zero from moved value
            next_s.z = (operand == 8'h00);
          end
          OP_STORE: begin
            wr = 1'b1;
            wval = s.acc;
            next_s.z = (s.acc == 8'h00);
          end
          // RULE3: constant is the byte after the opcode
          OP_LOADI_A: begin
            next_s.acc = s.b1;
            next_s.z = (s.b1 == 8'h00);
          end
          // RULE16: third byte written, flags kept
          OP_LOADI_M: begin
            wr = 1'b1;
            wval = prog_data_in;
          end
          // RULE9: only the selected bit changes
          OP_BSET: begin
            wr = 1'b1;
            wval = operand | mask;
          end
          OP_BCLR: begin
            wr = 1'b1;
            wval = operand & ~mask;
          end
          // RULE11: tested bit lands in carry
          OP_BTEST: begin
            next_s.c = operand[dif.bitn];
          end
          default: begin
          end
        endcase
        if (wr && is_scratch(s.daddr)) begin
          next_s.scr[s.daddr[1:0]] = wval;
        end else if (wr) begin
          next_s.dwe = 1'b1;
          next_s.dwd = wval;
        end
      end
      default: begin
      end
    endcase
    // Program counter and stack at the last phase
    case (dif.op)
      // RULE6: nibble then byte forms the target
      OP_JUMP, OP_CALL: begin
        next_pc = {s.ir[3:0], s.b1};
      end
      OP_RET: begin
        next_pc = s.stk[0];
      end
      // RULE8: condition picks target or next instruction
      OP_BRANCH: begin
        taken = (s.ir[6] ? s.c : s.z) == s.ir[5];
        if (taken && !s.ir[DIR_BIT]) begin
          next_pc = s.pc + 12'h001 + {8'h00, s.ir[3:0]};
        end else if (taken) begin
          next_pc = s.pc - {8'h00, s.ir[3:0]};
        end
      end
      // RULE10: signed displacement from own address
      OP_BTEST: begin
        taken = (s.c == dif.sense);
        if (taken) begin
          next_pc = s.pc + 12'h001 + {{4{s.b2[7]}}, s.b2};
        end
      end
      default: begin
      end
    endcase
    if (s.ph == last_ph) begin
      next_s.ph = 3'h0;
      next_s.pc = next_pc;
      next_s.fa = next_pc;
      // RULE2: push shifts deeper, oldest cell is lost
      if (dif.op == OP_CALL) begin
        next_s.stk = {s.stk[STACK_CELLS-2:0], s.pc + 12'h002};
      end else if (dif.op == OP_RET) begin
        next_s.stk = {12'h000, s.stk[STACK_CELLS-1:1]};
      end
    end else begin
      next_s.ph = s.ph + 3'h1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.pc <= PC_RST;
      s.fa <= PC_RST;
      s.acc <= ACC_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs, all from the state register except the done strobe
  assign prog_addr_out = s.fa;
  assign data_addr_out = s.daddr;
  assign data_wdata_out = s.dwd;
  assign data_we_out = s.dwe;
  assign acc_out = s.acc;
  assign zero_out = s.z;
  assign carry_out = s.c;
  assign pc_out = s.pc;
  assign bad_opcode_out = s.bad;
  // RULE17: retire strobe on the last phase
  assign instr_done_out = (s.ph == last_ph);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_imm_operand: assert property ( // RULE3
    (s.ph == 3'h1 && dif.op == OP_LOADI_A) |=> ##1
      (s.acc == $past(prog_data_in, 2)))
    else $error("immediate operand not the byte after opcode");

  a_direct_addr: assert property ( // RULE4
    (s.ph == 3'h1 && dif.mode == MODE_DIRECT) |=>
      (data_addr_out == $past(prog_data_in)))
    else $error("direct address not taken from second byte");

  a_short_internal: assert property ( // RULE5
    (s.ph == 3'h0 && dif.mode == MODE_SHORT) |=> ##2 !data_we_out)
    else $error("short-direct access reached the bus");

  a_ext_target: assert property ( // RULE6
    (instr_done_out && dif.op == OP_JUMP) |=>
      (s.pc == {$past(s.ir[3:0]), $past(s.b1)}))
    else $error("extended jump target wrong");

  a_rel_fall: assert property ( // RULE8
    (instr_done_out && dif.op == OP_BRANCH && !taken) |=>
      (s.pc == $past(s.pc) + 12'h001))
    else $error("untaken branch did not fall through");

  a_bit_only: assert property ( // RULE9
    (s.ph == 3'h2 && dif.op == OP_BSET && !is_scratch(s.daddr)) |=>
      data_we_out && data_wdata_out[$past(dif.bitn)] &&
      (((data_wdata_out ^ $past(data_rdata_in)) &
        ~(8'h01 << $past(dif.bitn))) == 8'h00))
    else $error("bit set altered more than one bit");

  a_ptr_select: assert property ( // RULE12
    (s.ph == 3'h0 && dif.mode == MODE_INDIRECT && dif.ptr_sel) |=>
      (data_addr_out == $past(s.scr[1])))
    else $error("indirect did not use second pointer");

  a_four_cycles: assert property ( // RULE17
    (s.ph == 3'h0 && dif.op inside {OP_LOAD, OP_STORE, OP_LOADI_A,
                                    OP_LOADI_M}) |->
      !instr_done_out ##1 !instr_done_out ##1 !instr_done_out
      ##1 instr_done_out)
    else $error("load form not four cycles");

  a_loadi_flags: assert property ( // RULE18
    (s.ph == 3'h2 && dif.op == OP_LOADI_M) |=> $stable(s.z) && $stable(s.c))
    else $error("immediate-to-memory touched flags");

  a_call_push: assert property ( // RULE2
    (instr_done_out && dif.op == OP_CALL) |=>
      (s.stk[0] == $past(s.pc) + 12'h002))
    else $error("call did not push return address");

endmodule // cals_core
`default_nettype wire

/* cals_mem_model.sv */
// Purpose: Program and data memory on the far side of the core
// Assumes: Both memories answer in the cycle the address stands
// Notes:   The bench loads contents through hierarchy between steps
`timescale 1ns/10ps
`default_nettype none
module cals_mem_model (
  input wire logic clk_in,
  input wire logic [11:0] prog_addr_in,
  output logic [7:0] prog_data_out,
  input wire logic [7:0] data_addr_in,
  output logic [7:0] data_rdata_out,
  input wire logic [7:0] data_wdata_in,
  input wire logic data_we_in
);
  logic [7:0] prog [0:4095];
  logic [7:0] dmem [0:255];

  // ==========================================================================
  // Reads
  // Asynchronous reads, since the core samples them in the same cycle
  assign prog_data_out = prog[prog_addr_in];
  assign data_rdata_out = dmem[data_addr_in];

  // ==========================================================================
  // Writes
  // Plain always, as the bench also preloads cells
  always @(posedge clk_in) begin
    if (data_we_in === 1'b1) begin
      dmem[data_addr_in] <= data_wdata_in;
    end
  end
endmodule // cals_mem_model
`default_nettype wire

/* test_core_addressing_load_store.sv */
// Purpose: Self-checking bench for the addressing and load/store core
// Assumes: Memory model answers at once; one 10 MHz clock
// Notes:   Each step places one instruction at the expected pc and runs it
`timescale 1ns/10ps
`default_nettype none
module test_core_addressing_load_store;
  import cals_pkg::*;
  logic clk_in, rst_in, we, zf, cf, done, bad, s, z, c;
  logic [11:0] prog_addr, pc_o, pc, rp;
  logic [7:0] prog_data, daddr, rdata, wdata, acc, a, r, n, o;
  int miscompares, checks, i;

  // ==========================================================================
  // Design and memories
  cals_core i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .prog_addr_out(prog_addr), .prog_data_in(prog_data),
    .data_addr_out(daddr), .data_rdata_in(rdata),
    .data_wdata_out(wdata), .data_we_out(we), .acc_out(acc),
    .zero_out(zf), .carry_out(cf), .pc_out(pc_o),
    .instr_done_out(done), .bad_opcode_out(bad));
  cals_mem_model i_mem (.clk_in(clk_in), .prog_addr_in(prog_addr),
    .prog_data_out(prog_data), .data_addr_in(daddr),
    .data_rdata_out(rdata), .data_wdata_in(wdata), .data_we_in(we));

  // Clock of 100 ns
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [11:0] seen,
                     input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Relative target: condition on zero or carry, then direction and span
  function automatic logic [11:0] rel_tgt(input logic [11:0] p,
      input logic [7:0] op, input logic zv, input logic cv);
    if ((op[6] ? cv : zv) != op[5]) return p + 12'h001;
    if (op[4]) return p - {8'h00, op[3:0]};
    return p + 12'h001 + {8'h00, op[3:0]};
  endfunction

  // Bit test target uses a signed byte displacement
  function automatic logic [11:0] bt_tgt(input logic [11:0] p,
      input logic [7:0] d, input logic t);
    return t ? p + 12'h001 + {{4{d[7]}}, d} : p + 12'h003;
  endfunction

  // Called in the opcode cycle; bounded wait for the last cycle
  task automatic step(input logic [7:0] b0, input logic [7:0] b1,
      input logic [7:0] b2, input int cyc, input logic [11:0] nxt);
    int k;
    i_mem.prog[pc] = b0;
    i_mem.prog[pc + 12'h001] = b1;
    i_mem.prog[pc + 12'h002] = b2;
    k = 1;
    while (done !== 1'b1 && k < 20) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 20) begin
      miscompares++;
      end_sim();
    end else begin
      chk("cycles", 12'(k), 12'(cyc));
      @(negedge clk_in);
      chk("next pc", pc_o, nxt);
      pc = nxt;
    end
  endtask

  // Scratch cells must stay inside the core
  always @(negedge clk_in) begin
    if (we === 1'b1 && daddr[7:2] == 6'h20) begin
      chk("scratch on bus", {4'h0, daddr}, 12'h000);
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_in = 1'b1;
    miscompares = 0;
    checks = 0;
    pc = 12'h000;
    z = 1'b0;
    c = 1'b0;
    void'($urandom(32'h52620888));
    for (i = 0; i < 4096; i++) i_mem.prog[i] = OPC_NOP;
    for (i = 0; i < 256; i++) i_mem.dmem[i] = 8'($urandom);
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    // Far jump leaves room for backward branches
    a = 8'($urandom);
    step(8'h68, a, 8'h00, 4, {4'h8, a});
    // Immediate, direct store, immediate to memory, direct load
    for (i = 0; i < 6; i++) begin
      n = (i == 0) ? 8'h00 : 8'($urandom);
      r = {1'b0, 7'($urandom)};
      o = 8'($urandom) | 8'h01;
      step(OPC_LDI_A, n, 8'h00, 4, pc + 12'h002);
      chk("acc", acc, n);
      chk("zero", zf, n == 8'h00);
      step(OPC_ST_DIR, r, 8'h00, 4, pc + 12'h002);
      chk("stored", i_mem.dmem[r], n);
      step(OPC_LDI_M, r ^ 8'h01, o, 4, pc + 12'h003);
      chk("imm to mem", i_mem.dmem[r ^ 8'h01], o);
      chk("flags kept", zf, n == 8'h00);
      step(OPC_LD_DIR, r ^ 8'h01, 8'h00, 4, pc + 12'h002);
      chk("loaded", acc, o);
    end
    // Each scratch cell keeps its own value
    for (i = 0; i < 4; i++) begin
      n = 8'($urandom);
      step(OPC_LDI_A, n, 8'h00, 4, pc + 12'h002);
      step({5'h01, 1'b0, 2'(i)}, 8'h00, 8'h00, 4, pc + 12'h001);
      step(OPC_LDI_A, ~n, 8'h00, 4, pc + 12'h002);
      step({6'h00, 2'(i)}, 8'h00, 8'h00, 4, pc + 12'h001);
      chk("scratch", acc, n);
    end
    // Indirect through both pointers
    r = {1'b0, 7'($urandom)};
    n = 8'($urandom);
    step(OPC_LDI_M, SCR_BASE, r, 4, pc + 12'h003);
    step(OPC_LDI_A, n, 8'h00, 4, pc + 12'h002);
    step(8'h21, 8'h00, 8'h00, 4, pc + 12'h001);
    chk("indirect store", i_mem.dmem[r], n);
    step(OPC_LDI_M, SCR_BASE | 8'h01, r ^ 8'h10, 4, pc + 12'h003);
    o = i_mem.dmem[r ^ 8'h10];
    step(8'h30, 8'h00, 8'h00, 4, pc + 12'h001);
    chk("indirect load", acc, o);
    z = (o == 8'h00);
    // Call, return, no-op and an unmapped opcode
    a = 8'($urandom);
    rp = pc + 12'h002;
    step(8'h5A, a, 8'h00, 4, {4'hA, a});
    step(OPC_RET, 8'h00, 8'h00, 2, rp);
    step(OPC_NOP, 8'h00, 8'h00, 2, pc + 12'h001);
    chk("legal opcode", bad, 1'b0);
    step(8'h46, 8'h00, 8'h00, 2, pc + 12'h001);
    chk("bad opcode", bad, 1'b1);
    // Bit set and clear touch one bit only
    for (i = 0; i < 4; i++) begin
      r = {1'b0, 7'($urandom)};
      o = 8'($urandom);
      i_mem.dmem[r] = o;
      n = {5'h00, 3'($urandom)};
      step({4'h7, i[0], n[2:0]}, r, 8'h00, 4, pc + 12'h002);
      o[n[2:0]] = ~i[0];
      chk("bit op", i_mem.dmem[r], o);
    end
    // Bit test with both displacement limits, then random ones
    for (i = 0; i < 6; i++) begin
      r = {1'b0, 7'($urandom)};
      o = 8'($urandom);
      i_mem.dmem[r] = o;
      n = {5'h00, 3'($urandom)};
      a = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      c = o[n[2:0]];
      s = (i < 2) ? c : i[0];
      step({4'h1, s, n[2:0]}, r, a, 5, bt_tgt(pc, a, c == s));
      chk("carry", cf, c);
    end
    // Relative branches over every condition, magnitudes 0 and 15 first
    for (i = 0; i < 16; i++) begin
      a = {1'b1, 2'(i), 1'($urandom), 4'($urandom)};
      if (i < 2) a[3:0] = {4{i[0]}};
      step(a, 8'h00, 8'h00, 2, rel_tgt(pc, a, z, c));
    end
    end_sim();
  end
endmodule // test_core_addressing_load_store
`default_nettype wire
